// File: pkg/acs_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: APB with 32-bit data, register byte address is four times the register index
// Notes: only the low byte of each register word carries data; upper bits read zero
package acs_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 8;
  // register indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_TRIM = 8'h67;
  localparam logic [IDX_W-1:0] IDX_TIMING = 8'h77;
  localparam logic [IDX_W-1:0] IDX_RES_LO = 8'h78;
  localparam logic [IDX_W-1:0] IDX_RES_HI = 8'h79;
  localparam logic [IDX_W-1:0] IDX_CSR = 8'h7A;
  localparam logic [IDX_W-1:0] IDX_CTRLB = 8'h7B;
  localparam logic [IDX_W-1:0] IDX_RSVD = 8'h7D;
  localparam logic [IDX_W-1:0] IDX_PIN_DIS = 8'h7E;
  // converter_control_status fields
  localparam int unsigned CSR_ON = 7;
  localparam int unsigned CSR_GO = 6;
  localparam int unsigned CSR_ATE = 5;
  localparam int unsigned CSR_FLAG = 4;
  localparam int unsigned CSR_IE = 3;
  localparam int unsigned CSR_DIV_LSB = 0;
  localparam int unsigned DIV_W = 3;
  // converter_timing_control fields
  localparam int unsigned TIM_THT_LSB = 6;
  localparam int unsigned THT_W = 2;
  localparam int unsigned TIM_SUT_LSB = 0;
  localparam int unsigned SUT_W = 6;
  // converter_control_b fields
  localparam int unsigned CTRLB_TSEL_LSB = 0;
  localparam int unsigned TSEL_W = 3;
  localparam int unsigned CTRLB_JUST = 3;
  // reference_trim fields
  localparam int unsigned TRIM_FINE_LSB = 3;
  localparam int unsigned FINE_W = 4;
  localparam int unsigned TRIM_COARSE_LSB = 0;
  localparam int unsigned COARSE_W = 3;
  localparam int unsigned FUSE_W = FINE_W + COARSE_W;
  // data widths and reset values
  localparam int unsigned RES_W = 10;
  localparam int unsigned NTRIG = 8;
  localparam int unsigned NPIN = 8;
  localparam int unsigned DIVCNT_W = 7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [DIV_W-1:0] DIV_CODE_MIN = 3'h2;
  // conversion sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WARM, ST_SAMPLE, ST_CONV} acs_state_t;
endpackage

// File: pkg/acs_div_if.sv
// Purpose: carries prescaler setting and converter clock tick between control and divider
// Assumes: single clock domain pclk
// Notes: tick is a one-cycle pulse once per converter clock period
interface acs_div_if;
  logic [2:0] sel;
  logic run;
  logic tick;
  modport ctrl (output sel, output run, input tick);
  modport div (input sel, input run, output tick);
endinterface

// File: design/acs_clkdiv.sv
// Purpose: converter clock prescaler, gives one tick every 2 to 128 pclk cycles
// Assumes: sel and run come from flip-flops on pclk
// Notes: counter restarts while run is low so the first period is always whole
module acs_clkdiv
  import acs_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  acs_div_if.div dif // prescaler setting and tick
);
  typedef struct packed {
    logic [DIVCNT_W-1:0] cnt;
    logic tick;
  } acs_div_st_t;

  acs_div_st_t s_q;
  acs_div_st_t s_d;
  logic [DIVCNT_W-1:0] lim;

  // prescaler ratio: codes 0 and 1 divide by 2, then powers of two
  always_comb begin
    lim = DIVCNT_W'(1);
    if (dif.sel >= DIV_CODE_MIN) begin
      lim = DIVCNT_W'((8'h01 << dif.sel) - 8'h01);
    end
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!dif.run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= lim) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + DIVCNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dif.tick = s_q.tick;
endmodule // acs_clkdiv

// File: design/acs_top.sv
// Purpose: control, status and result registers of a 10-bit successive-approximation converter
// Assumes: APB slave with zero wait states; analog core answers a start strobe with a done strobe
// Notes: read data is captured in the setup cycle and presented in the access cycle
// How it works
// - enable bit powers the converter; clearing it aborts a running conversion.
// - start write launches one conversion; in free running only the first.
// - first conversion after enabling is preceded by a warm-up period.
// - start bit reads one while converting, zero after; writing zero does nothing.
// - with auto-trigger on, each rising edge of selected trigger starts conversion when idle; edges while busy are ignored.
// - done flag sets when a conversion completes and the result is stored.
// - interrupt request while done flag, its enable and global enable are set.
// - done flag clears on interrupt vector execution or when written with one.
// - converter clock is system clock divided by 2 to 128 per divider code.
// - sample-hold field sets converter clock cycles used for sampling.
// - warm-up field sets converter clock cycles of analog start-up.
// - after low result byte read, result frozen until high byte read.
// - result right-justified by default, left-justified when the justify bit is set.
// - differential results appear in two's complement form.
// - pin disable bit switches off pin buffer and forces its input to zero.
// - reference trim loaded from fuses after power-up; software may overwrite.
// - trim bit 7 always reads zero and ignores writes.
// - four-bit fine trim steps the reference in 2mV units.
// - switching trigger source from cleared to set flag creates a triggering edge.
// - selecting free running mode creates no trigger event.
// - three-bit coarse trim steps the reference in 10mV units.
//
// The APB register port was chosen for this implementation.
module acs_top
  import acs_pkg::*;
(
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [acs_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [acs_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [acs_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  input wire logic global_irq_en, // core global interrupt enable
  input wire logic irq_ack, // pulse: done vector is executing
  input wire logic [acs_pkg::NTRIG-1:1] trig_in, // trigger source flags, codes 1 to 7
  input wire logic core_done, // pulse: analog core finished
  input wire logic [acs_pkg::RES_W-1:0] core_result, // result word with core_done
  input wire logic diff_channel, // current channel is differential
  input wire logic [acs_pkg::FUSE_W-1:0] fuse_trim, // fuse trim, fine above coarse
  input wire logic [acs_pkg::NPIN-1:0] port_pin_level, // digital pin levels
  output logic converter_power, // analog power enable
  output logic conv_clk_en, // pulse per converter clock period
  output logic track_hold, // sampling window active
  output logic conv_start, // pulse: begin conversion in core
  output logic conv_irq, // conversion complete interrupt request
  output logic [acs_pkg::NPIN-1:0] pin_buffer_disable, // digital input buffer off
  output logic [acs_pkg::NPIN-1:0] pin_read_value, // pin levels after masking
  output logic [acs_pkg::FINE_W-1:0] fine_trim, // reference fine trim
  output logic [acs_pkg::COARSE_W-1:0] coarse_trim // reference coarse trim
);
  import acs_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic on;
    logic go;
    logic ate;
    logic flag;
    logic ie;
    logic [DIV_W-1:0] div;
    logic [THT_W-1:0] tht;
    logic [SUT_W-1:0] sut;
    logic [TSEL_W-1:0] tsel;
    logic ljust;
    logic [7:0] pdis;
    logic [7:0] rsvd;
    logic [FINE_W-1:0] fine;
    logic [COARSE_W-1:0] coarse;
    logic fused;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic lock;
    logic warm_need;
    acs_state_t st;
    logic [SUT_W-1:0] cnt;
    logic strobe;
    logic [NTRIG-1:1] sy1;
    logic [NTRIG-1:1] sy2;
    logic [NTRIG-1:1] sy3;
    logic [NTRIG-1:1] tlvl;
    logic tprev;
    logic [NPIN-1:0] pinv;
    logic [DATA_W-1:0] rdata;
    logic err;
  } acs_st_t;

  acs_st_t s_q;
  acs_st_t s_d;
  acs_div_if dif ();

  logic [IDX_W-1:0] idx;
  logic mapped;
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wb;
  logic [7:0] rb;
  logic tcur;
  logic trig_edge;
  logic start_req;
  logic store_ok;
  logic [7:0] new_lo;
  logic [7:0] new_hi;

  // address decode, only the low byte of pwdata matters
  assign idx = paddr[IDX_W+1:2];
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_acc = psel & penable & ~pwrite & mapped;
  assign wb = pwdata[7:0];

  always_comb begin
    mapped = 1'b0;
    if (paddr[ADDR_W-1:IDX_W+2] == '0 && paddr[1:0] == 2'h0) begin
      case (idx)
        IDX_TRIM, IDX_TIMING, IDX_RES_LO, IDX_RES_HI: mapped = 1'b1;
        IDX_CSR, IDX_CTRLB, IDX_RSVD, IDX_PIN_DIS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // read mux, sampled into prdata during the setup cycle
  always_comb begin
    rb = RST_BYTE;
    case (idx)
      IDX_TRIM: rb = {1'b0, s_q.fine, s_q.coarse};
      IDX_TIMING: rb = {s_q.tht, s_q.sut};
      IDX_RES_LO: rb = s_q.res_lo;
      IDX_RES_HI: rb = s_q.res_hi;
      IDX_CSR: rb = {s_q.on, s_q.go, s_q.ate, s_q.flag, s_q.ie, s_q.div};
      IDX_CTRLB: rb = {4'h0, s_q.ljust, s_q.tsel};
      IDX_RSVD: rb = s_q.rsvd;
      IDX_PIN_DIS: rb = s_q.pdis;
      default: rb = RST_BYTE;
    endcase
  end

  // trigger selection and edge detection
  always_comb begin
    tcur = 1'b0;
    // free running code selects no source
    if (s_q.tsel != '0) begin
      tcur = s_q.tlvl[s_q.tsel];
    end
    // source switch also yields an edge
    trig_edge = tcur & ~s_q.tprev;
  end

  // result packing for the two data bytes
  always_comb begin
    new_lo = core_result[7:0];
    new_hi = {6'h00, core_result[RES_W-1:8]};
    if (diff_channel) begin
      new_hi = {{6{core_result[RES_W-1]}}, core_result[RES_W-1:8]};
    end
    if (s_q.ljust) begin
      new_hi = core_result[RES_W-1:2];
      new_lo = {core_result[1:0], 6'h00};
    end
  end

  // frozen while low byte read pending or being read
  assign store_ok = ~s_q.lock & ~(psel & mapped & ~pwrite & (idx == IDX_RES_LO));

  // next state
  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    start_req = 1'b0;
    // trigger input synchroniser, first stage feeds only the second
    s_d.sy1 = trig_in;
    s_d.sy2 = s_q.sy1;
    s_d.sy3 = s_q.sy2;
    s_d.tlvl = (~(s_q.sy2 ^ s_q.sy3) & s_q.sy3) | ((s_q.sy2 ^ s_q.sy3) & s_q.tlvl);
    s_d.tprev = tcur;
    s_d.pinv = port_pin_level & ~s_q.pdis;
    // fuse load once after reset release
    if (!s_q.fused) begin
      s_d.fused = 1'b1;
      s_d.fine = fuse_trim[FUSE_W-1:COARSE_W];
      s_d.coarse = fuse_trim[COARSE_W-1:0];
    end
    // apb capture in setup cycle
    if (setup_ph) begin
      s_d.rdata = {24'h000000, mapped ? rb : RST_BYTE};
      s_d.err = ~mapped;
    end
    if (irq_ack) begin
      s_d.flag = 1'b0;
    end
    // lock set by low read, released by high read
    if (rd_acc && idx == IDX_RES_LO) begin
      s_d.lock = 1'b1;
    end
    if (rd_acc && idx == IDX_RES_HI) begin
      s_d.lock = 1'b0;
    end
    if (wr_acc) begin
      case (idx)
        IDX_TRIM: begin
          s_d.fine = wb[TRIM_FINE_LSB +: FINE_W];
          s_d.coarse = wb[TRIM_COARSE_LSB +: COARSE_W];
        end
        IDX_TIMING: begin
          s_d.tht = wb[TIM_THT_LSB +: THT_W];
          s_d.sut = wb[TIM_SUT_LSB +: SUT_W];
        end
        IDX_CSR: begin
          s_d.on = wb[CSR_ON];
          s_d.ate = wb[CSR_ATE];
          s_d.ie = wb[CSR_IE];
          s_d.div = wb[CSR_DIV_LSB +: DIV_W];
          if (wb[CSR_FLAG]) begin
            s_d.flag = 1'b0;
          end
          if (wb[CSR_GO] && wb[CSR_ON]) begin
            start_req = 1'b1;
          end
        end
        IDX_CTRLB: begin
          s_d.tsel = wb[CTRLB_TSEL_LSB +: TSEL_W];
          s_d.ljust = wb[CTRLB_JUST];
        end
        IDX_RSVD: s_d.rsvd = wb;
        IDX_PIN_DIS: s_d.pdis = wb;
        default: s_d.rsvd = s_q.rsvd;
      endcase
    end
    if (s_q.on && s_q.ate && trig_edge) begin
      start_req = 1'b1;
    end
    // sequencer, warm-up and sampling count converter clock ticks, conversion waits for core_done
    case (s_q.st)
      ST_IDLE: begin
        if (start_req) begin
          s_d.go = 1'b1;
          s_d.cnt = '0;
          s_d.st = s_q.warm_need ? ST_WARM : ST_SAMPLE;
        end
      end
      ST_WARM: begin
        if (dif.tick) begin
          if (s_q.cnt >= s_q.sut) begin
            s_d.cnt = '0;
            s_d.warm_need = 1'b0;
            s_d.st = ST_SAMPLE;
          end else begin
            s_d.cnt = s_q.cnt + SUT_W'(1);
          end
        end
      end
      ST_SAMPLE: begin
        if (dif.tick) begin
          if (s_q.cnt >= SUT_W'(s_q.tht)) begin
            s_d.cnt = '0;
            s_d.strobe = 1'b1;
            s_d.st = ST_CONV;
          end else begin
            s_d.cnt = s_q.cnt + SUT_W'(1);
          end
        end
      end
      ST_CONV: begin
        if (core_done) begin
          if (store_ok) begin
            s_d.res_lo = new_lo;
            s_d.res_hi = new_hi;
            s_d.flag = 1'b1;
          end
          if (s_q.ate && s_q.tsel == '0) begin
            s_d.st = ST_SAMPLE;
          end else begin
            s_d.go = 1'b0;
            s_d.st = ST_IDLE;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (!s_d.on) begin
      s_d.st = ST_IDLE;
      s_d.go = 1'b0;
      s_d.cnt = '0;
      s_d.strobe = 1'b0;
      s_d.warm_need = 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.warm_need <= 1'b1;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign dif.sel = s_q.div;
  assign dif.run = s_q.on;

  acs_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .dif(dif)
  );

  // outputs
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = s_q.err & psel & penable;
  assign converter_power = s_q.on;
  assign conv_clk_en = dif.tick;
  assign track_hold = (s_q.st == ST_SAMPLE);
  assign conv_start = s_q.strobe;
  assign conv_irq = s_q.flag & s_q.ie & global_irq_en;
  assign pin_buffer_disable = s_q.pdis;
  assign pin_read_value = s_q.pinv;
  assign fine_trim = s_q.fine;
  assign coarse_trim = s_q.coarse;
endmodule // acs_top

// File: dv/acs_top_sva.sv
// Purpose: concurrent checks on the converter control block ports
// Assumes: one clock pclk, asynchronous active-low reset
// Notes: bound from the testbench top file
module acs_top_sva
  import acs_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic [acs_pkg::DATA_W-1:0] prdata, // apb read data
  input wire logic global_irq_en, // global interrupt enable
  input wire logic converter_power, // analog power
  input wire logic conv_clk_en, // converter tick
  input wire logic track_hold, // sampling window
  input wire logic conv_start, // core start strobe
  input wire logic conv_irq, // interrupt request
  input wire logic [acs_pkg::NPIN-1:0] pin_buffer_disable, // buffer off
  input wire logic [acs_pkg::NPIN-1:0] pin_read_value // masked pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // port relations
  a_irq_global: assert property (!global_irq_en |-> !conv_irq)
    else $error("interrupt without global enable");
  a_off_quiet: assert property (!converter_power |-> !track_hold && !conv_start)
    else $error("converter active while off");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start strobe longer than one cycle");
  a_start_after_hold: assert property ($rose(conv_start) |-> $past(track_hold))
    else $error("start strobe without sampling phase");
  a_pin_mask: assert property ($stable(pin_buffer_disable) |-> (pin_read_value & pin_buffer_disable) == '0)
    else $error("disabled pin reads one");
  a_tick_gap: assert property (conv_clk_en |=> !conv_clk_en)
    else $error("converter ticks closer than two cycles");
  a_tick_off: assert property (!converter_power [*3] |-> !conv_clk_en)
    else $error("converter tick while off");
  a_read_upper: assert property (psel && penable |-> prdata[31:8] == '0)
    else $error("read data upper bits set");
endmodule // acs_top_sva

// File: dv/acs_core_model.sv
// Purpose: behavioural analog conversion core answering start strobes
// Assumes: start is a one-cycle pulse on pclk
// Notes: result lines toggle outside the done pulse so stale values never match
module acs_core_model
  import acs_pkg::*;
#(
  parameter int LAT = 5 // cycles from start to done
)
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic conv_start, // start strobe from control
  input wire logic [acs_pkg::RES_W-1:0] next_res, // value to return
  output logic core_done, // completion strobe
  output logic [acs_pkg::RES_W-1:0] core_result // result word
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      core_done <= 1'b0;
      core_result <= '0;
    end else begin
      cnt <= conv_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
      core_done <= (cnt == 1);
      core_result <= (cnt == 1) ? next_res : ~core_result;
    end
  end
endmodule // acs_core_model

// File: dv/test_acs_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: zero-wait apb slave, behavioural analog core
// Notes: divider code 0 keeps conversions short
module test_acs_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, q;
  logic pready, pslverr, done, cpow, clken, th, cst, irq, err;
  logic gie = 1'b0, ack = 1'b0, diff = 1'b0;
  logic [NTRIG-1:1] trig = '0;
  logic [RES_W-1:0] cres, nres = '0;
  logic [FUSE_W-1:0] fuse = 7'h5A;
  logic [NPIN-1:0] pins = '0, pbd, prv;
  logic [FINE_W-1:0] ft;
  logic [COARSE_W-1:0] ct;
  int bad_count = 0, checked = 0;
  // free-running clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  acs_top u_acs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_en(gie), .irq_ack(ack), .trig_in(trig), .core_done(done), .core_result(cres),
    .diff_channel(diff), .fuse_trim(fuse), .port_pin_level(pins), .converter_power(cpow),
    .conv_clk_en(clken), .track_hold(th), .conv_start(cst), .conv_irq(irq),
    .pin_buffer_disable(pbd), .pin_read_value(prv), .fine_trim(ft), .coarse_trim(ct));
  acs_core_model u_acs_core_model (.pclk(pclk), .presetn(presetn), .conv_start(cst), .next_res(nres),
    .core_done(done), .core_result(cres));
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask
  // poll until the flag sets or the poll runs out
  task automatic wait_done(input logic f);
    int n;
    n = 0;
    do begin
      rd(IDX_CSR);
      n++;
    end while (q[CSR_FLAG] !== 1'b1 && n < 40);
    chk("done_flag", f, q[CSR_FLAG]);
    chk("busy_end", 1'h0, q[CSR_GO]);
  endtask
  // manual start with flag cleared in the same write
  task automatic conv(input logic [9:0] r, input logic f);
    nres = r;
    wr(IDX_CSR, 8'hD0);
    rd(IDX_CSR);
    chk("busy", 1'h1, q[CSR_GO]);
    wait_done(f);
  endtask
  // trim, pin disable and unmapped access
  task automatic s_regs();
    rd(IDX_TRIM);
    chk("trim_reset", 32'h5A, q);
    wr(IDX_TRIM, 8'hFF);
    rd(IDX_TRIM);
    chk("trim_bit7", 32'h7F, q);
    chk("fine", 4'hF, ft);
    chk("coarse", 3'h7, ct);
    wr(IDX_RSVD, 8'h00);
    pins <= 8'hFF;
    wr(IDX_PIN_DIS, 8'hA5);
    repeat (3) @(posedge pclk);
    chk("pin_read", 8'h5A, prv);
    chk("buf_off", 8'hA5, pbd);
    rd(8'h00);
    chk("unmapped", 1'h1, err);
  endtask
  // single conversion, interrupt and flag clearing
  task automatic s_single();
    wr(IDX_TIMING, 8'h41);
    conv(10'h2A5, 1'h1);
    rd(IDX_RES_LO);
    chk("res_lo", 32'hA5, q);
    rd(IDX_RES_HI);
    chk("res_hi", 32'h02, q);
    chk("irq_off", 1'h0, irq);
    gie <= 1'b1;
    wr(IDX_CSR, 8'h88);
    @(posedge pclk);
    chk("irq_on", 1'h1, irq);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    @(posedge pclk);
    chk("irq_ack", 1'h0, irq);
    conv(10'h155, 1'h1);
    wr(IDX_CSR, 8'h80);
    rd(IDX_CSR);
    chk("flag_w0", 1'h1, q[CSR_FLAG]);
    wr(IDX_CSR, 8'h90);
    rd(IDX_CSR);
    chk("flag_w1", 1'h0, q[CSR_FLAG]);
  endtask
  // left justify, read lock, differential sign
  task automatic s_lock();
    wr(IDX_CTRLB, 8'h08);
    conv(10'h2A5, 1'h1);
    rd(IDX_RES_LO);
    chk("left_lo", 32'h40, q);
    conv(10'h155, 1'h0);
    rd(IDX_RES_HI);
    chk("locked_hi", 32'hA9, q);
    conv(10'h155, 1'h1);
    rd(IDX_RES_HI);
    chk("left_hi", 32'h55, q);
    wr(IDX_CTRLB, 8'h00);
    diff <= 1'b1;
    conv(10'h3F0, 1'h1);
    rd(IDX_RES_HI);
    chk("diff_hi", 32'hFF, q);
    diff <= 1'b0;
  endtask
  // trigger edge, source switch, free running
  task automatic s_auto();
    trig <= 7'h02;
    wr(IDX_CTRLB, 8'h01);
    wr(IDX_CSR, 8'hB0);
    trig[1] <= 1'b1;
    wait_done(1'h1);
    trig <= 7'h02;
    wr(IDX_CSR, 8'hB0);
    repeat (6) @(posedge pclk);
    wr(IDX_CTRLB, 8'h02);
    wait_done(1'h1);
    trig <= '0;
    wr(IDX_CTRLB, 8'h00);
    repeat (10) @(posedge pclk);
    rd(IDX_CSR);
    chk("no_trigger", 1'h0, q[CSR_GO]);
    wr(IDX_CSR, 8'hF0);
    repeat (20) rd(IDX_CSR);
    chk("free_flag", 1'h1, q[CSR_FLAG]);
    chk("free_busy", 1'h1, q[CSR_GO]);
    // switch off first so a completion cannot land on the flag clear
    wr(IDX_CSR, 8'h00);
    wr(IDX_CSR, 8'h10);
    rd(IDX_CSR);
    chk("stopped", 32'h0, q);
  endtask
  // disable during warm-up
  task automatic s_abort();
    wr(IDX_TIMING, 8'h3F);
    wr(IDX_CSR, 8'hC7);
    rd(IDX_CSR);
    chk("warm_busy", 1'h1, q[CSR_GO]);
    wr(IDX_CSR, 8'h00);
    rd(IDX_CSR);
    chk("abort", 32'h0, q);
    chk("power", 1'h0, cpow);
  endtask
  // warm-up and sampling tick counts, start while busy, core result
  task automatic s_timing();
    int n;
    int m;
    n = 0;
    m = 0;
    nres = 10'h0C3;
    wr(IDX_TIMING, 8'h83);
    wr(IDX_CSR, 8'hC0);
    for (int i = 0; i < 400 && cst !== 1'b1; i++) begin
      @(posedge pclk);
      if (clken === 1'b1 && th !== 1'b1) begin
        n++;
      end
      if (clken === 1'b1 && th === 1'b1) begin
        m++;
      end
    end
    chk("warm_ticks", 32'h4, n);
    chk("hold_ticks", 32'h3, m);
    wr(IDX_CSR, 8'hC0);
    wait_done(1'h1);
    rd(IDX_CSR);
    chk("no_restart", 1'h0, q[CSR_GO]);
    rd(IDX_RES_LO);
    chk("core_res", 32'hC3, q);
  endtask
  // tick period for every divider code
  task automatic s_div();
    time t;
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CSR, {5'h10, c[2:0]});
      repeat (2) @(posedge clken);
      t = $time;
      @(posedge clken);
      chk("div", (c < 2) ? 2 : (1 << c), 32'(($time - t) / 10));
    end
    wr(IDX_CSR, 8'h00);
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_single();
    s_lock();
    s_auto();
    s_abort();
    s_timing();
    s_div();
    complete_run();
  end
  // hang guard
  initial begin
    #200us;
    bad_count++;
    complete_run();
  end
endmodule // test_acs_top
bind acs_top acs_top_sva u_acs_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .global_irq_en(global_irq_en), .converter_power(converter_power),
  .conv_clk_en(conv_clk_en), .track_hold(track_hold), .conv_start(conv_start), .conv_irq(conv_irq),
  .pin_buffer_disable(pin_buffer_disable), .pin_read_value(pin_read_value));
